// File: rtl/dca_defines.svh
// Offsets, field positions, reset values and counts of the command port.
`ifndef DCA_DEFINES_SVH
`define DCA_DEFINES_SVH

// ==========================================================================
// Register map
`define DCA_CTRL_OFF 12'h000
`define DCA_STAT_OFF 12'h004
`define DCA_REFCNT_OFF 12'h008
`define DCA_CTRL_RST 32'h0000_0001
`define DCA_CTRL_EN_BIT 0

// ==========================================================================
// Status word fields
`define DCA_ST_OPEN_LSB 0
`define DCA_ST_PD_BIT 8
`define DCA_ST_SR_BIT 9
`define DCA_ST_BUSY_BIT 10
`define DCA_ST_BT_BIT 11
`define DCA_ST_BL_LSB 12
`define DCA_ST_AL_LSB 14
`define DCA_ST_CL_LSB 16
`define DCA_ST_W 19
`define DCA_REF_W 16

// ==========================================================================
// Mode register fields and codes
`define DCA_MR0_BL_LSB 0
`define DCA_MR0_BT_BIT 3
`define DCA_MR0_CL_LSB 4
`define DCA_MR1_AL_LSB 3
`define DCA_MR_RST 13'h0000
`define DCA_BL_FIX8 2'h0
`define DCA_BL_OTF 2'h1
`define DCA_BL_FIX4 2'h2
`define DCA_AL_ZERO 2'h0
`define DCA_AL_CL1 2'h1
`define DCA_AL_CL2 2'h2
`define DCA_CL_BASE 5'h04

// ==========================================================================
// Address lines with extra meaning, burst counts and read latency trim
`define DCA_A_AP 10
`define DCA_A_BC 12
`define DCA_BEATS_BL8 2'h3
`define DCA_BEATS_BC4 2'h1
`define DCA_LAT_TRIM 5'h03

`endif

// File: rtl/dca_pkg.sv
// Types shared by the command port design files.
package dca_pkg;

    typedef enum logic [1:0] {
        DCA_IDLE,
        DCA_LAT,
        DCA_RD,
        DCA_WR
    } dca_state_e;

    typedef logic [2:0] dca_bank_t;
    typedef logic [12:0] dca_addr_t;
    typedef logic [15:0] dca_word_t;

endpackage

// File: rtl/dca_burst_mem.sv
// Two-port word store for burst data with byte-masked writes.
`timescale 1ns/100ps
`default_nettype none

module dca_burst_mem #(
    parameter int AW = 13,
    parameter int DW = 16
) (
    // Clock
    input wire logic clk,
    input wire logic ce,
    // Write pair
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr_a,
    input wire logic [DW-1:0] wr_data_a,
    input wire logic [DW/8-1:0] wr_be_a,
    input wire logic [AW-1:0] wr_addr_b,
    input wire logic [DW-1:0] wr_data_b,
    input wire logic [DW/8-1:0] wr_be_b,
    // Read pair
    input wire logic [AW-1:0] rd_addr_a,
    input wire logic [AW-1:0] rd_addr_b,
    output logic [DW-1:0] rd_data_a,
    output logic [DW-1:0] rd_data_b
);

    if (DW % 8 != 0 || AW < 4) begin : g_bad
        $error("dca_burst_mem: unsupported width or depth");
    end

    logic [DW-1:0] mem_reg [0:(1<<AW)-1];

    // ======================================================================
    // Storage
    always_ff @(posedge clk) begin
        for (int i = 0; i < DW/8; i++) begin
            if (ce && wr_en && wr_be_a[i]) begin
                mem_reg[wr_addr_a][8*i +: 8] <= wr_data_a[8*i +: 8];
            end
            if (ce && wr_en && wr_be_b[i]) begin
                mem_reg[wr_addr_b][8*i +: 8] <= wr_data_b[8*i +: 8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            rd_data_a <= mem_reg[rd_addr_a];
            rd_data_b <= mem_reg[rd_addr_b];
        end
    end

endmodule

`default_nettype wire

// File: rtl/dca_cmd_port.sv
// Command, address and data port of an eight-bank DDR3 memory device.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "dca_defines.svh"

module dca_cmd_port
    import dca_pkg::*;
#(
    parameter int COLW = 10
) (
    // APB clock, enable and reset
    input wire logic pclk,
    input wire logic pclk_en,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link clock and reset
    input wire logic ck,
    input wire logic reset_n,
    // Command and address
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire dca_bank_t ba,
    input wire dca_addr_t addr,
    // Data
    input wire dca_word_t dq_i,
    input wire logic [1:0] dm_i,
    output dca_word_t dq_rise_o,
    output dca_word_t dq_fall_o,
    output logic dq_oe
);

    localparam int AW = COLW + 3;

    if (COLW < 3 || COLW > 10) begin : g_bad
        $error("dca_cmd_port: COLW must lie between 3 and 10");
    end

    // ======================================================================
    // Link and APB domain state
    logic cke_q_reg;
    logic en_s1_reg, en_s2_reg;
    logic [7:0] open_reg;
    logic pd_reg, sr_reg;
    logic [12:0] mr0_reg, mr1_reg;
    logic [`DCA_REF_W-1:0] ref_reg;
    dca_state_e state_reg;
    logic [4:0] lat_reg;
    logic [1:0] beat_reg, last_reg;
    dca_bank_t bank_reg;
    logic [COLW-1:0] col_reg;
    logic ap_reg, wr_sel_reg;
    logic oe_pipe_reg, wr_go_reg;
    logic [31:0] ctrl_reg;
    logic [`DCA_ST_W+`DCA_REF_W-1:0] stat_reg;
    logic req_s1_reg, req_s2_reg, ack_reg;
    logic [1:0] wr_beat_reg;
    dca_word_t rise_in_reg, fall_in_reg, fall_hold_reg;
    logic [1:0] rise_dm_reg, fall_dm_reg;
    dca_word_t rd_a, rd_b;

    // The edge that samples cke low still acts; the one after it is frozen.
    wire run = cke_q_reg;
    wire cmd_ok = run && cke && en_s2_reg && !cs_n;
    wire cmd_act = cmd_ok && !ras_n && cas_n && we_n;
    wire cmd_pre = cmd_ok && !ras_n && cas_n && !we_n;
    wire cmd_rd = cmd_ok && ras_n && !cas_n && we_n;
    wire cmd_wr = cmd_ok && ras_n && !cas_n && !we_n;
    wire cmd_ref = cmd_ok && !ras_n && !cas_n && we_n;
    wire cmd_mrs = cmd_ok && !ras_n && !cas_n && !we_n;
    wire ck_low_cmd = !cs_n && !ras_n && !cas_n && we_n;
    wire pd_entry = run && !cke && open_reg == 8'h00;
    wire idle = state_reg == DCA_IDLE;
    wire col_go = (cmd_rd || cmd_wr) && idle;

    wire [1:0] bl_mode = mr0_reg[`DCA_MR0_BL_LSB +: 2];
    wire ilv = mr0_reg[`DCA_MR0_BT_BIT];
    wire [2:0] cl_code = mr0_reg[`DCA_MR0_CL_LSB +: 3];
    wire [1:0] al_code = mr1_reg[`DCA_MR1_AL_LSB +: 2];
    wire [4:0] cl = `DCA_CL_BASE + {2'h0, cl_code};
    wire [4:0] al = (al_code == `DCA_AL_CL1) ? cl - 5'h01 :
                    (al_code == `DCA_AL_CL2) ? cl - 5'h02 : 5'h00;
    wire [4:0] rl = al + cl;
    // On-the-fly mode lets line 12 choose; fixed modes ignore it.
    wire chop = (bl_mode == `DCA_BL_FIX4) ||
                (bl_mode == `DCA_BL_OTF && !addr[`DCA_A_BC]);
    wire [1:0] last_beat = chop ? `DCA_BEATS_BC4 : `DCA_BEATS_BL8;

    // Start column's low bits plus the word index, wrapped per burst type.
    function automatic logic [2:0] order(input logic [2:0] start,
                                         input logic [2:0] idx,
                                         input logic mode_ilv);
        if (mode_ilv) begin
            order = start ^ idx;
        end else begin
            order = {start[2] ^ idx[2], start[1:0] + idx[1:0]};
        end
    endfunction

    wire [2:0] idx_a = {beat_reg, 1'b0};
    wire [2:0] idx_b = {beat_reg, 1'b1};
    wire [2:0] widx_a = {wr_beat_reg, 1'b0};
    wire [2:0] widx_b = {wr_beat_reg, 1'b1};
    wire [AW-1:0] base = {bank_reg, col_reg[COLW-1:3], 3'h0};
    wire [AW-1:0] rd_addr_a = base | {{(AW-3){1'b0}},
                                      order(col_reg[2:0], idx_a, ilv)};
    wire [AW-1:0] rd_addr_b = base | {{(AW-3){1'b0}},
                                      order(col_reg[2:0], idx_b, ilv)};
    wire [AW-1:0] wr_addr_a = base | {{(AW-3){1'b0}},
                                      order(col_reg[2:0], widx_a, ilv)};
    wire [AW-1:0] wr_addr_b = base | {{(AW-3){1'b0}},
                                      order(col_reg[2:0], widx_b, ilv)};
    // A high mask clears the lane's write enable.
    wire [1:0] be_a = ~rise_dm_reg;
    wire [1:0] be_b = ~fall_dm_reg;

    // ======================================================================
    // Command decoding, banks and mode registers
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            cke_q_reg <= 1'b0;
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
        end else begin
            cke_q_reg <= cke;
            en_s1_reg <= ctrl_reg[`DCA_CTRL_EN_BIT];
            en_s2_reg <= en_s1_reg;
        end
    end

    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            open_reg <= 8'h00;
            pd_reg <= 1'b0;
            sr_reg <= 1'b0;
            mr0_reg <= `DCA_MR_RST;
            mr1_reg <= `DCA_MR_RST;
            ref_reg <= '0;
        end else if (run) begin
            pd_reg <= pd_entry;
            sr_reg <= pd_entry && ck_low_cmd;
            if (cmd_act) begin
                open_reg[ba] <= 1'b1;
            end else if (cmd_pre && addr[`DCA_A_AP]) begin
                open_reg <= 8'h00;
            end else if (cmd_pre) begin
                open_reg[ba] <= 1'b0;
            end else if (state_reg != DCA_IDLE && state_reg != DCA_LAT &&
                         beat_reg == last_reg && ap_reg) begin
                open_reg[bank_reg] <= 1'b0;
            end
            if (cmd_mrs && ba == 3'h0) begin
                mr0_reg <= addr;
            end
            if (cmd_mrs && ba == 3'h1) begin
                mr1_reg <= addr;
            end
            if (cmd_ref) begin
                ref_reg <= ref_reg + 16'h0001;
            end
        end
    end

    // ======================================================================
    // Burst sequencing
    // One column access is in flight at a time; others are dropped.
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= DCA_IDLE;
            lat_reg <= 5'h00;
            beat_reg <= 2'h0;
            last_reg <= 2'h0;
            bank_reg <= 3'h0;
            col_reg <= '0;
            ap_reg <= 1'b0;
            wr_sel_reg <= 1'b0;
        end else if (run) begin
            case (state_reg)
                DCA_IDLE: begin
                    if (col_go) begin
                        state_reg <= DCA_LAT;
                        lat_reg <= rl - `DCA_LAT_TRIM;
                        bank_reg <= ba;
                        col_reg <= addr[COLW-1:0];
                        ap_reg <= addr[`DCA_A_AP];
                        last_reg <= last_beat;
                        beat_reg <= 2'h0;
                        // Write flag rides in the low state bit on exit.
                        wr_sel_reg <= cmd_wr;
                    end
                end
                DCA_LAT: begin
                    if (lat_reg == 5'h00) begin
                        state_reg <= wr_sel_reg ? DCA_WR : DCA_RD;
                    end else begin
                        lat_reg <= lat_reg - 5'h01;
                    end
                end
                DCA_RD, DCA_WR: begin
                    if (beat_reg == last_reg) begin
                        state_reg <= DCA_IDLE;
                    end else begin
                        beat_reg <= beat_reg + 2'h1;
                    end
                end
                default: state_reg <= DCA_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Data path: read words on both ck edges, write words caught on both
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            oe_pipe_reg <= 1'b0;
            dq_oe <= 1'b0;
            dq_rise_o <= '0;
            fall_hold_reg <= '0;
            wr_go_reg <= 1'b0;
            wr_beat_reg <= 2'h0;
            rise_in_reg <= '0;
            rise_dm_reg <= 2'h0;
        end else if (run) begin
            oe_pipe_reg <= state_reg == DCA_RD;
            dq_oe <= oe_pipe_reg;
            if (oe_pipe_reg) begin
                dq_rise_o <= rd_a;
                fall_hold_reg <= rd_b;
            end
            wr_go_reg <= state_reg == DCA_WR;
            wr_beat_reg <= beat_reg;
            rise_in_reg <= dq_i;
            rise_dm_reg <= dm_i;
        end
    end

    always_ff @(negedge ck or negedge reset_n) begin
        if (!reset_n) begin
            dq_fall_o <= '0;
            fall_in_reg <= '0;
            fall_dm_reg <= 2'h0;
        end else if (run) begin
            dq_fall_o <= fall_hold_reg;
            fall_in_reg <= dq_i;
            fall_dm_reg <= dm_i;
        end
    end

    dca_burst_mem #(
        .AW(AW),
        .DW(16)
    ) u_mem (
        .clk(ck),
        .ce(run),
        .wr_en(wr_go_reg),
        .wr_addr_a(wr_addr_a),
        .wr_data_a(rise_in_reg),
        .wr_be_a(be_a),
        .wr_addr_b(wr_addr_b),
        .wr_data_b(fall_in_reg),
        .wr_be_b(be_b),
        .rd_addr_a(rd_addr_a),
        .rd_addr_b(rd_addr_b),
        .rd_data_a(rd_a),
        .rd_data_b(rd_b)
    );

    // ======================================================================
    // Status snapshot crossing by toggle handshake
    logic [`DCA_ST_W-1:0] st_live;
    logic [`DCA_ST_W+`DCA_REF_W-1:0] snap_reg;
    logic req_reg, ack_s1_reg, ack_s2_reg;

    always_comb begin
        st_live = '0;
        st_live[`DCA_ST_OPEN_LSB +: 8] = open_reg;
        st_live[`DCA_ST_PD_BIT] = pd_reg;
        st_live[`DCA_ST_SR_BIT] = sr_reg;
        st_live[`DCA_ST_BUSY_BIT] = !idle;
        st_live[`DCA_ST_BT_BIT] = ilv;
        st_live[`DCA_ST_BL_LSB +: 2] = bl_mode;
        st_live[`DCA_ST_AL_LSB +: 2] = al_code;
        st_live[`DCA_ST_CL_LSB +: 3] = cl_code;
    end

    // The word is held still while a request is outstanding.
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            snap_reg <= '0;
            req_reg <= 1'b0;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= ack_reg;
            ack_s2_reg <= ack_s1_reg;
            if (req_reg == ack_s2_reg) begin
                snap_reg <= {ref_reg, st_live};
                req_reg <= ~req_reg;
            end
        end
    end

    // ======================================================================
    // APB slave, one wait state per access
    wire acc = psel && penable && !pready;
    wire hit_ctrl = paddr == `DCA_CTRL_OFF;
    wire hit_stat = paddr == `DCA_STAT_OFF;
    wire hit_ref = paddr == `DCA_REFCNT_OFF;
    wire hit = hit_ctrl || hit_stat || hit_ref;
    wire [31:0] rd_mux = hit_ctrl ? ctrl_reg :
        hit_stat ? {{(32-`DCA_ST_W){1'b0}}, stat_reg[`DCA_ST_W-1:0]} :
        hit_ref ? {16'h0000, stat_reg[`DCA_ST_W +: `DCA_REF_W]} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `DCA_CTRL_RST;
            stat_reg <= '0;
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            ack_reg <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (pclk_en) begin
            req_s1_reg <= req_reg;
            req_s2_reg <= req_s1_reg;
            if (req_s2_reg != ack_reg) begin
                stat_reg <= snap_reg;
                ack_reg <= req_s2_reg;
            end
            pready <= acc;
            pslverr <= acc && !hit;
            prdata <= (acc && !pwrite) ? rd_mux : 32'h0;
            if (acc && pwrite && hit_ctrl) begin
                ctrl_reg <= {31'h0, pwdata[`DCA_CTRL_EN_BIT]};
            end
        end
    end

endmodule

`default_nettype wire

// File: rtl/dca_cmd_port_fix.sv
// Reserved.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: dv/dca_cmd_port_monitor.sv
// Checker of the command port, bound to its pins.
`timescale 1ns/100ps
`default_nettype none
module dca_cmd_port_monitor
    import dca_pkg::*;
#(
    parameter int COLW = 10
) (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Link side
    input wire logic ck,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire dca_bank_t ba,
    input wire dca_addr_t addr,
    input wire dca_word_t dq_rise_o,
    input wire logic dq_oe
);
    // ==========
    // Own decode of the mode registers, so a wrong design decode shows.
    logic cke_reg;
    logic bl4_reg;
    logic [6:0] mr0_reg;
    logic [1:0] al_reg;
    logic [4:0] cnt_reg;
    logic [4:0] rl;
    logic tk;
    logic rd;
    logic mrs;
    assign tk = cke && cke_reg && !cs_n;
    assign rd = tk && ras_n && !cas_n && we_n;
    assign mrs = tk && !ras_n && !cas_n && !we_n;
    assign rl = 5'(mr0_reg[6:4]) + 5'h04 + (al_reg == 2'h1 ?
        5'(mr0_reg[6:4]) + 5'h03 : al_reg == 2'h2 ?
        5'(mr0_reg[6:4]) + 5'h02 : 5'h00);
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            cke_reg <= 1'b0;
            mr0_reg <= 7'h00;
            al_reg <= 2'h0;
            bl4_reg <= 1'b0;
            cnt_reg <= 5'h00;
        end else begin
            cke_reg <= cke;
            if (mrs && ba == 3'h0)
                mr0_reg <= addr[6:0];
            if (mrs && ba == 3'h1)
                al_reg <= addr[4:3];
            if (rd && cnt_reg == 5'h00)
                bl4_reg <= mr0_reg[1:0] == 2'h2 ||
                    (mr0_reg[1:0] == 2'h1 && !addr[12]);
            if (rd && cnt_reg == 5'h00)
                cnt_reg <= 5'h01;
            else if (cnt_reg == rl)
                cnt_reg <= 5'h00;
            else if (cnt_reg != 5'h00)
                cnt_reg <= cnt_reg + 5'h01;
        end
    end
    sequence s_burst8;
        dq_oe [*4] ##1 !dq_oe;
    endsequence
    sequence s_burst4;
        dq_oe [*2] ##1 !dq_oe;
    endsequence
    rd_latency_a: assert property (@(posedge ck) disable iff (!reset_n)
        cnt_reg == rl |-> !dq_oe ##1 dq_oe)
        else $error("read data not at the read latency");
    rd_source_a: assert property (@(posedge ck) disable iff (!reset_n)
        $rose(dq_oe) |-> $past(cnt_reg) == rl)
        else $error("read data without a read command");
    burst_long_a: assert property (@(posedge ck) disable iff (!reset_n)
        $rose(dq_oe) && !bl4_reg |-> s_burst8)
        else $error("long burst not four clocks");
    burst_chop_a: assert property (@(posedge ck) disable iff (!reset_n)
        $rose(dq_oe) && bl4_reg |-> s_burst4)
        else $error("chopped burst not two clocks");
    ck_freeze_a: assert property (@(posedge ck) disable iff (!reset_n)
        !$past(cke) && !cke |=> $stable(dq_oe) && $stable(dq_rise_o))
        else $error("outputs moved while clock enable low");
    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(penable) && psel |-> !pready ##1 pready)
        else $error("access phase not one wait");
    apb_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready longer than one cycle");
    apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004
            || paddr == 12'h008))
        else $error("error flag wrong for address");
endmodule
bind dca_cmd_port dca_cmd_port_monitor #(.COLW(COLW)) dca_mon_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .ck(ck),
    .reset_n(reset_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .dq_rise_o(dq_rise_o), .dq_oe(dq_oe));
`default_nettype wire

// File: dv/dca_host_model.sv
// Memory controller model driving the command bus of the port.
`timescale 1ns/100ps
`default_nettype none
module dca_host_model
    import dca_pkg::*;
(
    // Link clock
    input wire logic ck,
    // Command bus and write data
    output var logic cke,
    output var logic cs_n,
    output var logic ras_n,
    output var logic cas_n,
    output var logic we_n,
    output var dca_bank_t ba,
    output var dca_addr_t addr,
    output var dca_word_t dq_i,
    output var logic [1:0] dm_i
);
    // ==========
    // Idle bank, address, data and mask lines show the inverse of their last value, so a stale
    // address or word never passes for a fresh one.
    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        ras_n = 1'b1;
        cas_n = 1'b1;
        we_n = 1'b1;
        ba = 3'h0;
        addr = 13'h0000;
        dq_i = 16'h0000;
        dm_i = 2'h0;
    end
    task automatic cmd(input logic [2:0] c, input dca_bank_t b,
                       input dca_addr_t a);
        @(posedge ck);
        cs_n <= 1'b0;
        {ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        @(posedge ck);
        cs_n <= 1'b1;
        ba <= ~b;
        addr <= ~a;
    endtask
    // Clock enable is lowered for n clocks without checking that every bank is closed.
    task automatic sleep(input int n);
        @(posedge ck);
        cke <= 1'b0;
        repeat (n) @(posedge ck);
        cke <= 1'b1;
    endtask
    task automatic wr(input dca_bank_t b, input dca_addr_t a, input int wl,
                      input dca_word_t w [8], input logic [1:0] m);
        cmd(3'b100, b, a);
        repeat (wl - 1) @(posedge ck);
        dq_i <= w[0];
        dm_i <= m;
        for (int i = 0; i < 8; i += 2) begin
            @(posedge ck);
            dq_i <= w[i+1];
            @(negedge ck);
            dq_i <= (i < 6) ? w[i+2] : ~w[i+1];
        end
        dm_i <= ~m;
    endtask
endmodule
`default_nettype wire

// File: dv/dca_cmd_port_tb.sv
// Self-checking bench of the command port.
`timescale 1ns/100ps
`default_nettype none
`include "dca_defines.svh"
module dca_cmd_port_tb
    import dca_pkg::*;
;
    logic pclk = 1'b0;
    logic ck = 1'b0;
    logic presetn = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, cke, cs_n, ras_n, cas_n, we_n, dq_oe;
    dca_bank_t ba;
    dca_addr_t addr;
    dca_word_t dq_i, dq_rise_o, dq_fall_o;
    logic [1:0] dm_i;
    int err_total = 0;
    int n_checks = 0;
    int rl = 4;
    logic ilv = 1'b0;
    dca_word_t mem [int];
    initial begin
        forever #20 pclk = ~pclk;
    end
    initial begin
        #7;
        forever #80 ck = ~ck;
    end
    dca_cmd_port dca_cmd_port_inst (
        .pclk(pclk), .pclk_en(1'b1), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ck(ck),
        .reset_n(reset_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_i(dq_i),
        .dm_i(dm_i), .dq_rise_o(dq_rise_o), .dq_fall_o(dq_fall_o),
        .dq_oe(dq_oe));
    dca_host_model dca_host_model_inst (
        .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dq_i(dq_i), .dm_i(dm_i));
    // ==========
    // Shared tasks.
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        e = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16) begin
            err_total++;
            wrap_up();
        end
    endtask
    // Status is a delayed snapshot, so it is polled a bounded number
    // of times before the final compare.
    task automatic poll(input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, a, 32'h0, q, e);
            if ((q & m) === exp)
                break;
        end
        chk(q & m, exp);
    endtask
    function automatic logic [12:0] key(input dca_bank_t b,
                                        input logic [9:0] s, input int i);
        logic [2:0] j;
        j = 3'(i);
        return ilv ? {b, s[9:3], s[2:0] ^ j}
                   : {b, s[9:3], s[2] ^ j[2], 2'(s[1:0] + j[1:0])};
    endfunction
    task automatic wblk(input dca_bank_t b, input logic [9:0] c,
                        input dca_word_t base, input logic [1:0] m);
        dca_word_t w [8];
        int k;
        for (int i = 0; i < 8; i++) begin
            w[i] = base + 16'(i);
            k = int'(key(b, c, i));
            mem[k] = {m[1] ? mem[k][15:8] : w[i][15:8],
                      m[0] ? mem[k][7:0] : w[i][7:0]};
        end
        dca_host_model_inst.wr(b, {3'h0, c}, rl - 1, w, m);
    endtask
    task automatic rblk(input dca_bank_t b, input logic [9:0] c,
                        input logic bc_n, input int n);
        dca_host_model_inst.cmd(3'b101, b, {bc_n, 2'h0, c});
        repeat (rl) @(posedge ck);
        for (int i = 0; i < n; i += 2) begin
            @(negedge ck);
            chk({dq_oe, dq_rise_o}, {1'b1, mem[int'(key(b, c, i))]});
            @(posedge ck);
            chk(dq_fall_o, mem[int'(key(b, c, i + 1))]);
        end
        @(negedge ck);
        chk(dq_oe, 1'b0);
    endtask
    // ==========
    // Scenarios.
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        poll(`DCA_CTRL_OFF, 32'hffffffff, `DCA_CTRL_RST);
        poll(`DCA_REFCNT_OFF, 32'hffffffff, 32'h0);
        apb(1'b1, 12'h00c, 32'h5a5a5a5a, q, e);
        chk(e, 1'b1);
        apb(1'b0, 12'h00c, 32'h0, q, e);
        chk({e, q}, {1'b1, 32'h0});
    endtask
    task automatic t_data;
        dca_host_model_inst.cmd(3'b011, 3'h3, 13'h1abc);
        dca_host_model_inst.cmd(3'b011, 3'h4, 13'h0042);
        poll(`DCA_STAT_OFF, 32'hff, 32'h18);
        wblk(3'h3, 10'h000, 16'ha000, 2'h0);
        wblk(3'h4, 10'h318, 16'hb000, 2'h0);
        rblk(3'h3, 10'h005, 1'b1, 8);
        rblk(3'h4, 10'h31a, 1'b1, 8);
        wblk(3'h3, 10'h000, 16'h5500, 2'h1);
        rblk(3'h3, 10'h000, 1'b1, 8);
    endtask
    task automatic t_modes;
        dca_host_model_inst.cmd(3'b000, 3'h0, 13'h0008);
        ilv = 1'b1;
        rblk(3'h3, 10'h005, 1'b1, 8);
        dca_host_model_inst.cmd(3'b000, 3'h0, 13'h0002);
        ilv = 1'b0;
        rblk(3'h3, 10'h006, 1'b1, 4);
        dca_host_model_inst.cmd(3'b000, 3'h0, 13'h0001);
        rblk(3'h3, 10'h003, 1'b0, 4);
        rblk(3'h3, 10'h003, 1'b1, 8);
        dca_host_model_inst.cmd(3'b000, 3'h1, 13'h0008);
        rl = 7;
        poll(`DCA_STAT_OFF, 32'hf000, 32'h5000);
        rblk(3'h3, 10'h001, 1'b1, 8);
        dca_host_model_inst.cmd(3'b000, 3'h1, 13'h0010);
        rl = 6;
        rblk(3'h4, 10'h31c, 1'b1, 8);
    endtask
    task automatic t_pd;
        dca_host_model_inst.cmd(3'b010, 3'h4, 13'h0000);
        poll(`DCA_STAT_OFF, 32'hff, 32'h08);
        dca_host_model_inst.cmd(3'b010, 3'h0, 13'h0400);
        poll(`DCA_STAT_OFF, 32'hff, 32'h00);
        dca_host_model_inst.cmd(3'b001, 3'h0, 13'h0000);
        poll(`DCA_REFCNT_OFF, 32'hffff, 32'h1);
        fork
            dca_host_model_inst.sleep(40);
            poll(`DCA_STAT_OFF, 32'h100, 32'h100);
        join
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        reset_n <= 1'b1;
        repeat (8) @(posedge ck);
        t_regs();
        t_data();
        t_modes();
        t_pd();
        wrap_up();
    end
endmodule
`default_nettype wire
